//--- rtl/lcd_ctrl.sv
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - Code 01 fills display memory with spaces, zeroes counter, long busy.
// - Return home zeroes counter and shift, keeps memory, long busy.
// - Entry mode latches direction and display shift enable, short busy.
// - Display control latches display, cursor and blink bits.
// - Shift moves cursor or whole display, memory untouched.
// - Function set takes width, line count and font height.
// - Glyph address loads six bits and selects glyph RAM.
// - Display address loads seven bits and selects display memory.
// - Status read gives busy flag on bit 7 and counter below.
// - Data write stores byte in selected memory, short busy.
// - Data read returns byte at counter from selected memory.
// - Reset alone starts clear and initial settings, no host action.
// - Two-line panel shows 80-87 on line 1, C0-C7 on line 2.
// - 80 display locations, unseen ones usable as storage.
// - Glyph ROM gives 192 short and 64 tall patterns by code.
// - Glyph RAM holds eight short or four tall user glyphs.
// - 16 commons, 40 segments; only selected line commons drive.
// - Host access and refresh reads use separate memory ports.
// - Select high is data; low is instruction or status.
// - Four-bit mode moves upper nibble then lower on bits 7:4.
module lcd_ctrl
   import lcd_pkg::*;
#(
   parameter int LONG_CYCLES  = LONG_EXEC_CYCLES,
   parameter int SHORT_CYCLES = SHORT_EXEC_CYCLES
) (
   input  wire logic                i_clk_sys,
   input  wire logic                i_rst_n,
   input  wire logic                i_address,
   input  wire logic                i_read,
   input  wire logic                i_write,
   input  wire logic [7:0]          i_writedata,
   output logic      [7:0]          o_readdata,
   output logic                     o_waitrequest,
   output logic      [COMMONS-1:0]  o_common,
   output logic      [SEGMENTS-1:0] o_segment
);
   acc_state_t        acc_state;
   ref_state_t        rf_state;
   mode_t             mode;
   logic [6:0]        address_counter;
   logic              sel_glyph;
   logic [5:0]        display_offset;
   logic [BUSY_W-1:0] busy_count;
   logic              busy_flag;
   logic              clearing;
   logic [6:0]        clear_ptr;
   logic              nibble_phase;
   logic [3:0]        nibble_hold;
   logic [3:0]        low_hold;
   logic [7:0]        cmd_byte;
   logic              commit;
   logic              byte_done;
   logic              exec_ok;
   logic              instr_go;
   logic              data_wr_go;
   logic              data_rd_go;
   logic              disp_valid;
   logic [6:0]        disp_a_addr;
   logic              disp_a_we;
   logic [7:0]        disp_a_wdata;
   logic [7:0]        disp_a_q;
   logic              glyph_a_we;
   logic [7:0]        glyph_a_q;
   logic [7:0]        full_read;
   logic [3:0]        rf_row;
   logic [2:0]        rf_col;
   logic [34:0]       seg_acc;
   logic [BLINK_W-1:0] blink_cnt;
   logic              rf_line;
   logic [3:0]        prow;
   logic              row_live;
   logic [5:0]        pos;
   logic [6:0]        disp_b_addr;
   logic [7:0]        disp_b_q;
   logic [5:0]        glyph_b_addr;
   logic [7:0]        glyph_b_q;
   logic [4:0]        pix;
   logic [7:0]        cmd_q;

   function automatic logic [6:0] step_ac(input logic [6:0] a,
                                          input logic up,
                                          input logic glyph);
      logic [6:0] r;
      r = up ? a + 7'h01 : a - 7'h01;
      if (glyph) begin
         r = {1'b0, r[5:0]};
      end else if (up) begin
         if (a == L1_LAST) r = L2_FIRST;
         else if (a == L2_LAST) r = 7'h00;
      end else begin
         if (a == 7'h00) r = L2_LAST;
         else if (a == L2_FIRST) r = L1_LAST;
      end
      return r;
   endfunction

   function automatic logic [5:0] wrap_off(input logic [5:0] o,
                                           input logic up);
      logic [5:0] r;
      r = 6'h00;
      if (up) r = (o == LINE_LEN - 6'h01) ? 6'h00 : o + 6'h01;
      else    r = (o == 6'h00) ? LINE_LEN - 6'h01 : o - 6'h01;
      return r;
   endfunction

   function automatic logic [4:0] rom_row(input logic [7:0] c,
                                          input logic [3:0] r,
                                          input logic tall);
      logic       in_set;
      logic [3:0] last;
      in_set = tall ? (c >= ROM_TALL_LO)
                    : (c >= ROM_SHORT_LO && c <= ROM_SHORT_HI);
      last   = tall ? ROWS_TALL - 4'h1 : ROWS_SHORT - 4'h1;
      if (!in_set || r == last) return 5'h00;
      return c[4:0] ^ {r[2:0], r[3], 1'b1};
   endfunction

   // Host side decode
   assign busy_flag  = (busy_count != '0);
   assign commit     = (acc_state == ACC_ANSWER) && (i_read || i_write);
   assign byte_done  = mode.interface_width || nibble_phase;
   assign cmd_byte   = mode.interface_width ? i_writedata
                       : {nibble_hold, i_writedata[7:4]};
   assign exec_ok    = commit && byte_done && !busy_flag;
   assign instr_go   = exec_ok && i_write && !i_address;
   assign data_wr_go = exec_ok && i_write && i_address;
   assign data_rd_go = exec_ok && i_read && i_address;

   assign disp_valid = address_counter[5:0] < LINE_LEN;
   assign disp_a_addr = clearing ? clear_ptr
                      : address_counter[6] ? {1'b0, address_counter[5:0]}
                        + {1'b0, LINE_LEN} : {1'b0, address_counter[5:0]};
   assign disp_a_we  = clearing
                       || (data_wr_go && !sel_glyph && disp_valid);
   assign disp_a_wdata = clearing ? SPACE_CODE : cmd_byte;
   assign glyph_a_we = data_wr_go && sel_glyph;
   assign full_read  = !i_address ? {busy_flag, address_counter}
                     : sel_glyph ? glyph_a_q
                     : disp_valid ? disp_a_q : 8'h00;

   char_ram #(.DEPTH(DISP_DEPTH), .AW(7)) u_display_memory (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_a_addr  (disp_a_addr),
      .i_a_we    (disp_a_we),
      .i_a_wdata (disp_a_wdata),
      .o_a_rdata (disp_a_q),
      .i_b_addr  (disp_b_addr),
      .o_b_rdata (disp_b_q)
   );

   char_ram #(.DEPTH(GLYPH_DEPTH), .AW(6)) u_glyph_ram (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_a_addr  (address_counter[5:0]),
      .i_a_we    (glyph_a_we),
      .i_a_wdata (cmd_byte),
      .o_a_rdata (glyph_a_q),
      .i_b_addr  (glyph_b_addr),
      .o_b_rdata (glyph_b_q)
   );

   // Bus handshake: fetch, answer, release
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         acc_state     <= ACC_IDLE;
         o_waitrequest <= 1'b1;
         o_readdata    <= 8'h00;
         low_hold      <= 4'h0;
      end else begin
         case (acc_state)
            ACC_IDLE: begin
               if (i_read || i_write) acc_state <= ACC_FETCH;
            end
            ACC_FETCH: begin
               acc_state     <= ACC_ANSWER;
               o_waitrequest <= 1'b0;
               if (!mode.interface_width && nibble_phase) begin
                  o_readdata <= {low_hold, 4'h0};
               end else begin
                  o_readdata <= full_read;
                  low_hold   <= full_read[3:0];
               end
            end
            ACC_ANSWER: begin
               acc_state     <= ACC_IDLE;
               o_waitrequest <= 1'b1;
            end
            default: begin
               acc_state     <= ACC_IDLE;
               o_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Nibble pairing
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         nibble_phase <= 1'b0;
         nibble_hold  <= 4'h0;
      end else if (commit) begin
         nibble_phase <= mode.interface_width ? 1'b0 : ~nibble_phase;
         if (i_write && !nibble_phase) nibble_hold <= i_writedata[7:4];
      end
   end

   // Busy timer
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         busy_count <= BUSY_W'(LONG_CYCLES);
      end else if (instr_go && cmd_byte[7:1] == 7'h00 && cmd_byte[0]) begin
         busy_count <= BUSY_W'(LONG_CYCLES);
      end else if (instr_go && cmd_byte[7:1] == 7'h01) begin
         busy_count <= BUSY_W'(LONG_CYCLES);
      end else if (instr_go || data_wr_go || data_rd_go) begin
         busy_count <= BUSY_W'(SHORT_CYCLES);
      end else if (busy_flag) begin
         busy_count <= busy_count - BUSY_W'(1);
      end
   end

   // Clear walk
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         clearing  <= 1'b1;
         clear_ptr <= 7'h00;
      end else if (instr_go && cmd_byte == CMD_CLEAR) begin
         clearing  <= 1'b1;
         clear_ptr <= 7'h00;
      end else if (clearing) begin
         clearing  <= (clear_ptr != CLEAR_LAST);
         clear_ptr <= clear_ptr + 7'h01;
      end
   end

   // Address counter and memory select
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         address_counter <= 7'h00;
         sel_glyph       <= 1'b0;
      end else if (instr_go) begin
         casez (cmd_byte)
            8'b1???????: begin
               address_counter <= cmd_byte[6:0];
               sel_glyph       <= 1'b0;
            end
            8'b01??????: begin
               address_counter <= {1'b0, cmd_byte[5:0]};
               sel_glyph       <= 1'b1;
            end
            8'b0001????: begin
               if (!cmd_byte[SHIFT_SEL_BIT]) begin
                  address_counter <= step_ac(address_counter,
                                        cmd_byte[SHIFT_DIR_BIT], sel_glyph);
               end
            end
            8'b0000001?, 8'b00000001: begin
               address_counter <= 7'h00;
               sel_glyph       <= 1'b0;
            end
            default: begin
               address_counter <= address_counter;
            end
         endcase
      end else if (data_wr_go || data_rd_go) begin
         address_counter <= step_ac(address_counter, mode.increment,
                                    sel_glyph);
      end
   end

   // Display shift offset
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         display_offset <= 6'h00;
      end else if (instr_go && cmd_byte[7:2] == 6'h00
                   && cmd_byte != 8'h00) begin
         display_offset <= 6'h00;
      end else if (instr_go && cmd_byte[7:4] == 4'h1
                   && cmd_byte[SHIFT_SEL_BIT]) begin
         display_offset <= wrap_off(display_offset,
                                    !cmd_byte[SHIFT_DIR_BIT]);
      end else if (data_wr_go && mode.shift_on && !sel_glyph) begin
         display_offset <= wrap_off(display_offset, mode.increment);
      end
   end

   // Mode bits
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         mode <= MODE_RESET;
      end else if (instr_go) begin
         casez (cmd_byte)
            8'b001?????: begin
               mode.interface_width <= cmd_byte[WIDTH_BIT];
               mode.two_lines       <= cmd_byte[LINES_BIT];
               mode.tall_font       <= cmd_byte[FONT_BIT];
            end
            8'b00001???: begin
               mode.disp_on   <= cmd_byte[DISP_ON_BIT];
               mode.cursor_on <= cmd_byte[CURSOR_BIT];
               mode.blink_on  <= cmd_byte[BLINK_BIT];
            end
            8'b000001??: begin
               mode.increment <= cmd_byte[ENTRY_DIR_BIT];
               mode.shift_on  <= cmd_byte[ENTRY_SHIFT_BIT];
            end
            default: begin
               mode <= mode;
            end
         endcase
      end
   end

   // Refresh scan on the second memory ports
   assign rf_line  = mode.two_lines & rf_row[3];
   assign prow     = mode.two_lines ? {1'b0, rf_row[2:0]} : rf_row;
   assign row_live = mode.two_lines
                     || prow < (mode.tall_font ? ROWS_TALL : ROWS_SHORT);
   assign pos      = ({3'b000, rf_col} + display_offset >= LINE_LEN)
                     ? {3'b000, rf_col} + display_offset - LINE_LEN
                     : {3'b000, rf_col} + display_offset;
   assign disp_b_addr = rf_line ? {1'b0, pos} + {1'b0, LINE_LEN}
                                : {1'b0, pos};
   assign glyph_b_addr = mode.tall_font ? {disp_b_q[2:1], prow}
                                        : {disp_b_q[2:0], prow[2:0]};

   always_comb begin
      pix = (disp_b_q[7:4] == 4'h0) ? glyph_b_q[4:0]
          : rom_row(disp_b_q, prow, mode.tall_font);
      if (mode.cursor_on && !sel_glyph && address_counter == {rf_line, pos}
          && prow == (mode.tall_font ? ROWS_TALL : ROWS_SHORT) - 4'h1) begin
         pix = 5'h1f;
      end
      if (mode.blink_on && !sel_glyph && blink_cnt[BLINK_W-1]
          && address_counter == {rf_line, pos}) begin
         pix = 5'h1f;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         blink_cnt <= '0;
      end else begin
         blink_cnt <= blink_cnt + BLINK_W'(1);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         rf_state  <= RF_CODE;
         rf_row    <= 4'h0;
         rf_col    <= 3'h0;
         seg_acc   <= '0;
         o_segment <= '0;
         o_common  <= '0;
      end else begin
         case (rf_state)
            RF_CODE:  rf_state <= RF_GLYPH;
            RF_GLYPH: rf_state <= RF_PIXEL;
            RF_PIXEL: begin
               rf_state <= RF_CODE;
               seg_acc  <= {seg_acc[29:0], pix};
               rf_col   <= rf_col + 3'h1;
               if (rf_col == 3'h7) begin
                  o_segment <= (mode.disp_on && row_live)
                               ? {seg_acc, pix} : '0;
                  o_common  <= row_live ? COMMONS'(1) << rf_row : '0;
                  rf_row    <= rf_row + 4'h1;
               end
            end
            default: rf_state <= RF_CODE;
         endcase
      end
   end

   // Checks
   always_ff @(posedge i_clk_sys) begin
      cmd_q <= cmd_byte;
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   sequence s_req_start;
      acc_state == ACC_IDLE && (i_read || i_write);
   endsequence
   sequence s_answer;
      o_waitrequest ##1 !o_waitrequest;
   endsequence

   bus_answer_a: assert property (s_req_start |=> s_answer)
      else $error("answer not given two cycles after request");
   status_read_a: assert property (acc_state == ACC_FETCH && i_read
      && !i_address && mode.interface_width
      |=> o_readdata == {$past(busy_flag), $past(address_counter)})
      else $error("status read mismatch");
   clear_run_a: assert property (instr_go && cmd_byte == CMD_CLEAR
      |=> (address_counter == 7'h00 && clearing
           && busy_count == LONG_CYCLES) ##80 !clearing)
      else $error("clear sequence wrong");
   clear_fill_a: assert property (clearing
      |-> disp_a_we && disp_a_wdata == SPACE_CODE)
      else $error("clear not writing spaces");
   home_exec_a: assert property (instr_go && cmd_byte[7:1] == 7'h01
      |=> address_counter == 7'h00 && display_offset == 6'h00
          && busy_count == LONG_CYCLES)
      else $error("return home wrong");
   entry_mode_a: assert property (instr_go && cmd_byte[7:2] == 6'h01
      |=> mode.increment == cmd_q[1] && mode.shift_on == cmd_q[0]
          && busy_count == SHORT_CYCLES)
      else $error("entry mode not latched");
   disp_ctl_a: assert property (instr_go && cmd_byte[7:3] == 5'h01
      |=> {mode.disp_on, mode.cursor_on, mode.blink_on} == cmd_q[2:0])
      else $error("display control not latched");
   func_set_a: assert property (instr_go && cmd_byte[7:5] == 3'h1
      |=> {mode.interface_width, mode.two_lines, mode.tall_font}
          == cmd_q[4:2])
      else $error("function set not latched");
   set_glyph_a: assert property (instr_go && cmd_byte[7:6] == 2'b01
      |=> sel_glyph && address_counter == {1'b0, cmd_q[5:0]})
      else $error("glyph address not loaded");
   set_disp_a: assert property (instr_go && cmd_byte[7]
      |=> !sel_glyph && address_counter == cmd_q[6:0])
      else $error("display address not loaded");
   ac_step_a: assert property (data_wr_go && sel_glyph && mode.increment
      |=> address_counter[5:0] == $past(address_counter[5:0]) + 6'h01)
      else $error("counter did not step");
endmodule

//--- rtl/lcd_pkg.sv
package lcd_pkg;
   // Clock and execution times
   localparam int CLK_MHZ           = 250;
   localparam int LONG_EXEC_NS      = 1520000;
   localparam int SHORT_EXEC_NS     = 38000;
   localparam int LONG_EXEC_CYCLES  = LONG_EXEC_NS * CLK_MHZ / 1000;
   localparam int SHORT_EXEC_CYCLES = SHORT_EXEC_NS * CLK_MHZ / 1000;
   localparam int BUSY_W            = 19;

   // Instruction codes and field positions
   localparam logic [7:0] CMD_CLEAR  = 8'h01;
   localparam int ENTRY_DIR_BIT      = 1;
   localparam int ENTRY_SHIFT_BIT    = 0;
   localparam int DISP_ON_BIT        = 2;
   localparam int CURSOR_BIT         = 1;
   localparam int BLINK_BIT          = 0;
   localparam int SHIFT_SEL_BIT      = 3;
   localparam int SHIFT_DIR_BIT      = 2;
   localparam int WIDTH_BIT          = 4;
   localparam int LINES_BIT          = 3;
   localparam int FONT_BIT           = 2;

   // Memory geometry
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam int DISP_DEPTH         = 80;
   localparam int GLYPH_DEPTH        = 64;
   localparam logic [6:0] CLEAR_LAST = 7'h4f;
   localparam logic [5:0] LINE_LEN   = 6'h28;
   localparam logic [6:0] L1_LAST    = 7'h27;
   localparam logic [6:0] L2_FIRST   = 7'h40;
   localparam logic [6:0] L2_LAST    = 7'h67;

   // Panel drive
   localparam int COMMONS            = 16;
   localparam int SEGMENTS           = 40;
   localparam logic [3:0] ROWS_SHORT = 4'h8;
   localparam logic [3:0] ROWS_TALL  = 4'ha;
   localparam logic [7:0] ROM_SHORT_LO = 8'h10;
   localparam logic [7:0] ROM_SHORT_HI = 8'hcf;
   localparam logic [7:0] ROM_TALL_LO  = 8'hc0;
   localparam int BLINK_W            = 24;

   typedef struct packed {
      logic interface_width;
      logic two_lines;
      logic tall_font;
      logic disp_on;
      logic cursor_on;
      logic blink_on;
      logic increment;
      logic shift_on;
   } mode_t;

   localparam mode_t MODE_RESET = 8'b1000_0010;

   typedef enum logic [1:0] {
      ACC_IDLE   = 2'b00,
      ACC_FETCH  = 2'b01,
      ACC_ANSWER = 2'b10
   } acc_state_t;

   typedef enum logic [1:0] {
      RF_CODE  = 2'b00,
      RF_GLYPH = 2'b01,
      RF_PIXEL = 2'b10
   } ref_state_t;
endpackage

//--- rtl/char_ram.sv
`timescale 1ns/1ps
module char_ram #(
   parameter int DEPTH = 80,
   parameter int AW    = 7
) (
   input  wire logic          i_clk_sys,
   input  wire logic          i_rst_n,
   input  wire logic [AW-1:0] i_a_addr,
   input  wire logic          i_a_we,
   input  wire logic [7:0]    i_a_wdata,
   output logic      [7:0]    o_a_rdata,
   input  wire logic [AW-1:0] i_b_addr,
   output logic      [7:0]    o_b_rdata
);
   logic [7:0] mem [DEPTH];

   // Host port writes, both ports read registered
   always_ff @(posedge i_clk_sys) begin
      if (i_a_we && (int'(i_a_addr) < DEPTH)) begin
         mem[i_a_addr] <= i_a_wdata;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_a_rdata <= 8'h00;
         o_b_rdata <= 8'h00;
      end else begin
         o_a_rdata <= (int'(i_a_addr) < DEPTH) ? mem[i_a_addr] : 8'h00;
         o_b_rdata <= (int'(i_b_addr) < DEPTH) ? mem[i_b_addr] : 8'h00;
      end
   end
endmodule

//--- verif/host_model.sv
`timescale 1ns/1ps
module host_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_waitrequest,
   input  wire logic [7:0] i_readdata,
   output logic            o_address,
   output logic            o_read,
   output logic            o_write,
   output logic [7:0]      o_writedata
);
   int timeouts = 0;
   initial begin
      o_address = 1'b0;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 8'h00;
   end
   // One bus cycle, held until waitrequest is sampled low
   task automatic xfer(input logic rs, input logic wr, input logic [7:0] wd,
                       output logic [7:0] rd);
      int n;
      n = 0;
      o_address <= rs;
      o_write <= wr;
      o_read <= !wr;
      o_writedata <= wd;
      @(posedge i_clk_sys);
      while (i_waitrequest !== 1'b0 && n < 50) begin
         @(posedge i_clk_sys);
         n++;
      end
      if (i_waitrequest !== 1'b0) timeouts++;
      rd = i_readdata;
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_writedata <= ~wd;
      @(posedge i_clk_sys);
   endtask
endmodule

//--- verif/test_lcd_ctrl.sv
`timescale 1ns/1ps
module test_lcd_ctrl;
   import lcd_pkg::*;
   logic       i_clk_sys;
   logic       i_rst_n;
   logic       address;
   logic       read;
   logic       write;
   logic [7:0] writedata;
   logic [7:0] readdata;
   logic       waitrequest;
   logic [7:0] v;
   logic [7:0] d;
   logic [6:0] a;
   logic [7:0] codes [6] = '{8'h0f, 8'h1f, 8'h18, 8'h3f, 8'h38, 8'h08};
   int         seed;
   int         mismatches;
   int         total_checks;
   logic [COMMONS-1:0]  common;
   logic [SEGMENTS-1:0] segment;
   logic [15:0]         com_seen;
   logic                seg_seen;

   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end

   lcd_ctrl #(.LONG_CYCLES(200), .SHORT_CYCLES(20)) i_lcd_ctrl (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_address(address),
      .i_read(read), .i_write(write), .i_writedata(writedata),
      .o_readdata(readdata), .o_waitrequest(waitrequest),
      .o_common(common), .o_segment(segment));

   host_model i_host_model (
      .i_clk_sys(i_clk_sys), .i_waitrequest(waitrequest),
      .i_readdata(readdata), .o_address(address), .o_read(read),
      .o_write(write), .o_writedata(writedata));

   function automatic logic [6:0] next_addr(input logic [6:0] x);
      if (x == L1_LAST) return L2_FIRST;
      if (x == L2_LAST) return 7'h00;
      return x + 7'h01;
   endfunction

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test;
      mismatches += i_host_model.timeouts;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // One bus access; a stuck answer ends the run
   task automatic bus(input logic rs, input logic wr, input logic [7:0] wd,
                      output logic [7:0] rd);
      i_host_model.xfer(rs, wr, wd, rd);
      if (i_host_model.timeouts != 0) finish_test();
   endtask

   task automatic status(output logic [7:0] s);
      bus(1'b0, 1'b0, 8'h00, s);
   endtask

   // Poll busy flag with a bounded count
   task automatic wait_idle;
      logic [7:0] s;
      int n;
      n = 0;
      s = 8'h80;
      while (s[7] !== 1'b0 && n < 300) begin
         status(s);
         n++;
      end
      if (s[7] !== 1'b0) begin
         mismatches++;
         finish_test();
      end
   endtask

   task automatic put(input logic rs, input logic [7:0] x);
      logic [7:0] r;
      bus(rs, 1'b1, x, r);
      wait_idle();
   endtask

   task automatic get(output logic [7:0] x);
      bus(1'b1, 1'b0, 8'h00, x);
      wait_idle();
   endtask

   // Byte as two nibble writes, then wait the short time
   task automatic nib(input logic rs, input logic [7:0] x);
      logic [7:0] r;
      bus(rs, 1'b1, x, r);
      bus(rs, 1'b1, {x[3:0], 4'h0}, r);
      repeat (30) @(posedge i_clk_sys);
   endtask

   // Collect commons and segments over one full scan
   task automatic scan(output logic [15:0] c, output logic s);
      c = 16'h0000;
      s = 1'b0;
      repeat (400) begin
         @(posedge i_clk_sys);
         c = c | common;
         s = s | (|segment);
      end
   endtask

   initial begin
      seed = 89;
      mismatches = 0;
      total_checks = 0;
      i_rst_n = 1'b0;
      repeat (20) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      @(posedge i_clk_sys);
      status(v);
      check("boot busy", 8'h80, v & 8'h80);
      wait_idle();
      status(v);
      check("boot counter", 8'h00, v);
      put(1'b0, 8'h85);
      get(v);
      check("boot fill", SPACE_CODE, v);
      scan(com_seen, seg_seen);
      check("boot commons", 8'hff, com_seen[7:0]);
      check("boot unused commons", 8'h00, com_seen[15:8]);
      check("boot segments", 8'h00, {7'h00, seg_seen});
      $display("test boot done");
      for (int i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         a = 7'($unsigned($random(seed)) % 40);
         if (d[0]) a = a + L2_FIRST;
         if (i < 2) a = i[0] ? L2_LAST : L1_LAST;
         put(1'b0, {1'b1, a});
         put(1'b1, d);
         status(v);
         check("counter step", {1'b0, next_addr(a)}, v);
         put(1'b0, {1'b1, a});
         get(v);
         check("display data", d, v);
      end
      $display("test display memory done");
      put(1'b0, 8'h04);
      put(1'b0, 8'h85);
      put(1'b1, 8'h5a);
      status(v);
      check("decrement", 8'h04, v);
      put(1'b0, 8'h06);
      put(1'b0, 8'h7f);
      put(1'b1, 8'h15);
      status(v);
      check("glyph wrap", 8'h00, v);
      put(1'b0, 8'h7f);
      get(v);
      check("glyph data", 8'h15, v);
      $display("test entry and glyph done");
      foreach (codes[k]) put(1'b0, codes[k]);
      put(1'b0, 8'h85);
      get(v);
      check("kept memory", 8'h5a, v);
      scan(com_seen, seg_seen);
      check("two line commons", 8'hff, com_seen[15:8]);
      check("display off segments", 8'h00, {7'h00, seg_seen});
      $display("test control codes done");
      bus(1'b0, 1'b1, 8'h28, v);
      repeat (30) @(posedge i_clk_sys);
      nib(1'b0, 8'hcc);
      nib(1'b1, 8'h3c);
      bus(1'b0, 1'b0, 8'h00, v);
      check("nibble status high", 8'h40, v & 8'hf0);
      bus(1'b0, 1'b0, 8'h00, v);
      check("nibble status low", 8'hd0, v);
      nib(1'b0, 8'hcc);
      bus(1'b1, 1'b0, 8'h00, v);
      check("nibble data high", 8'h30, v & 8'hf0);
      bus(1'b1, 1'b0, 8'h00, v);
      check("nibble data low", 8'hc0, v);
      repeat (30) @(posedge i_clk_sys);
      nib(1'b0, 8'h38);
      put(1'b0, 8'hcc);
      get(v);
      check("nibble stored", 8'h3c, v);
      $display("test nibble mode done");
      bus(1'b0, 1'b1, CMD_CLEAR, v);
      bus(1'b1, 1'b1, 8'h99, v);
      repeat (40) @(posedge i_clk_sys);
      status(v);
      check("clear busy", 8'h80, v & 8'h80);
      wait_idle();
      status(v);
      check("clear counter", 8'h00, v);
      put(1'b0, 8'h85);
      get(v);
      check("clear fill", SPACE_CODE, v);
      put(1'b0, 8'h8a);
      put(1'b1, 8'h77);
      bus(1'b0, 1'b1, 8'h03, v);
      repeat (40) @(posedge i_clk_sys);
      status(v);
      check("home busy", 8'h80, v & 8'h80);
      wait_idle();
      status(v);
      check("home counter", 8'h00, v);
      put(1'b0, 8'h8a);
      get(v);
      check("home memory", 8'h77, v);
      $display("test clear and home done");
      finish_test();
   end
endmodule
